// [cfg_loader_pkg.sv]
// Package of constants and types for the configuration loader
package cfg_loader_pkg;

  localparam int ADDR_W         = 18;
  localparam int DATA_W         = 8;
  localparam int ROW_BYTES      = 8;
  localparam int ROW_COUNT      = 4;
  localparam int ROW_IDX_W      = 3;
  localparam int ROW_NUM_W      = 8;
  localparam int BIT_IDX_W      = 3;
  localparam int CLEAR_CYCLES_W = 16;

  localparam logic [ADDR_W-1:0]         ADDR_ZERO     = 18'h00000;
  localparam logic [ADDR_W-1:0]         ADDR_ONE      = 18'h00001;
  localparam logic [ROW_IDX_W-1:0]      LAST_DATA_IDX = 3'h6;
  localparam logic [ROW_IDX_W-1:0]      CHECK_IDX     = 3'h7;
  localparam logic [ROW_IDX_W-1:0]      IDX_ZERO      = 3'h0;
  localparam logic [ROW_IDX_W-1:0]      IDX_ONE       = 3'h1;
  localparam logic [BIT_IDX_W-1:0]      BIT_LAST      = 3'h7;
  localparam logic [BIT_IDX_W-1:0]      BIT_ZERO      = 3'h0;
  localparam logic [BIT_IDX_W-1:0]      BIT_ONE       = 3'h1;
  localparam logic [ROW_NUM_W-1:0]      ROW_ZERO      = 8'h00;
  localparam logic [ROW_NUM_W-1:0]      ROW_ONE       = 8'h01;
  localparam logic [ROW_NUM_W-1:0]      ROW_LAST      = 8'h03;
  localparam logic [DATA_W-1:0]         CHECK_SEED    = 8'h00;
  localparam logic [DATA_W-1:0]         ID_BYTE       = 8'h5A; // Arbitrary identifier value
  localparam logic [1:0]                WRITE_CYCLES  = 2'h2;
  localparam logic [1:0]                WAIT_ZERO     = 2'h0;
  localparam logic [1:0]                WAIT_ONE      = 2'h1;
  localparam logic [CLEAR_CYCLES_W-1:0] CLEAR_CYCLES  = 16'h0010;
  localparam logic [CLEAR_CYCLES_W-1:0] CLEAR_ZERO    = 16'h0000;
  localparam logic [CLEAR_CYCLES_W-1:0] CLEAR_ONE     = 16'h0001;

  // Mode select codes
  localparam logic [1:0] MODE_INT_ADDR = 2'h1;
  localparam logic [1:0] MODE_SERIAL   = 2'h2;
  localparam logic [1:0] MODE_EXT_BYTE = 2'h3;

  typedef enum logic [3:0] {
    ST_CLEAR  = 4'h0,
    ST_PRE    = 4'h1,
    ST_FETCH  = 4'h2,
    ST_WRITE  = 4'h3,
    ST_DONE   = 4'h4,
    ST_INPUTS = 4'h5,
    ST_USER   = 4'h6,
    ST_FAULT  = 4'h7
  } load_state_t;

endpackage

// [cfg_skid_buffer.sv]
// Two-entry valid/ready buffer for captured configuration bytes
`timescale 1ns/100ps
module cfg_skid_buffer (
  input  wire logic                             clk_i,
  input  wire logic                             reset_i,
  input  wire logic                             enable_i,
  input  wire logic                             in_valid_i,
  output logic                                  in_ready_o,
  input  wire logic [cfg_loader_pkg::DATA_W-1:0] in_data_i,
  output logic                                  out_valid_o,
  input  wire logic                             out_ready_i,
  output logic      [cfg_loader_pkg::DATA_W-1:0] out_data_o
);

  logic [cfg_loader_pkg::DATA_W-1:0] slot_reg [2];
  logic [1:0]                        count_reg;
  logic                              rd_ptr_reg;
  logic                              wr_ptr_reg;
  wire                               push;
  wire                               pop;

  // Honest flags: full at two entries, empty at none
  assign in_ready_o  = (count_reg != 2'h2);
  assign out_valid_o = (count_reg != 2'h0);
  assign out_data_o  = slot_reg[rd_ptr_reg];
  assign push        = enable_i & in_valid_i & in_ready_o;
  assign pop         = enable_i & out_valid_o & out_ready_i;

  // Storage written only on push, so no reset is needed on data
  always_ff @(posedge clk_i) begin
    if (push) begin
      slot_reg[wr_ptr_reg] <= in_data_i;
    end
  end

  // Pointers and occupancy
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      count_reg  <= 2'h0;
      rd_ptr_reg <= 1'b0;
      wr_ptr_reg <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr_reg <= ~wr_ptr_reg;
      end
      if (pop) begin
        rd_ptr_reg <= ~rd_ptr_reg;
      end
      if (push & ~pop) begin
        count_reg <= count_reg + 2'h1;
      end else if (pop & ~push) begin
        count_reg <= count_reg - 2'h1;
      end
    end
  end

endmodule

// [cfg_store_model.sv]
// Behavioural configuration store, addressed or self-counting
`timescale 1ns/100ps
module cfg_store_model (
  input  wire logic        clk_i,
  input  wire logic [1:0]  mode_i,
  input  wire logic        strobe_i,
  input  wire logic        memory_enable_n_i,
  input  wire logic [17:0] pointer_i,
  input  wire logic        bad_i,
  output logic      [7:0]  data_o
);
  logic [17:0] count_reg = 18'h00000;
  logic        strobe_reg = 1'b0;
  logic [7:0]  last_reg = 8'hA5;
  logic [17:0] addr;
  logic [7:0]  byte_val;
  // Seven row bytes then their XOR; the stream opens with the identifier
  function automatic logic [7:0] plain(int a);
    return (a == 0) ? 8'h5A : 8'(a * 3 + 1);
  endfunction
  function automatic logic [7:0] rom_byte(int a);
    logic [7:0] x;
    x = 8'h00;
    if (a % 8 != 7) return plain(a);
    for (int i = a - 7; i < a; i++) x ^= plain(i);
    return x;
  endfunction
  // Counter held at zero while disabled, stepped on each strobe rise
  always_ff @(posedge clk_i) begin
    strobe_reg <= strobe_i;
    count_reg  <= memory_enable_n_i ? 18'h00000 : count_reg + 18'(strobe_i & !strobe_reg);
    if (!memory_enable_n_i) last_reg <= data_o;
  end
  assign addr     = (mode_i == 2'h1) ? pointer_i : (mode_i == 2'h2) ? count_reg >> 3 : count_reg;
  assign byte_val = rom_byte(int'(addr)) ^ {7'h00, bad_i && addr == 18'h0000F};
  // Released line shows the inverse of its last value, so a stale read fails
  assign data_o = memory_enable_n_i ? ~last_reg : (mode_i == 2'h2) ?
                  {~last_reg[7:1], byte_val[3'h7 - count_reg[2:0]]} : byte_val;
endmodule

// [rom_boot_config_loader.sv]
// Boot-from-store configuration loader: fetch, row check, row write, user enables
// Operation
// [RULE_01] Mode 1 drives an 18-bit address and captures data a byte at a time.
// [RULE_02] Address pins float during clear, drive while loading, release in user mode.
// [RULE_03] Advance strobe floats until one clock before memory enable falls.
// [RULE_04] Mode 1 first address with enable fall; first capture two clocks later.
// [RULE_05] Mode 1 address counter steps on each rising advance strobe edge.
// [RULE_06] After a checked row, hold address and keep strobe high during row write.
// [RULE_07] Row write bracketed by start and finish marks, then fetching resumes.
// [RULE_08] Done raised; one clock later inputs enabled, enable high, strobe floated.
// [RULE_09] One clock after inputs, outputs enabled and user mode entered.
// [RULE_10] Check byte mismatch raises fault two clocks after that byte.
// [RULE_11] Fault halts loading until boot initiate, reset or power cycle.
// [RULE_12] After done the strobe is an input; its rising edges step counter until release.
// [RULE_13] Boot initiate fall drives memory enable high within three clocks.
// [RULE_14] Boot initiate fall disables user logic and drops done within three clocks.
// [RULE_15] Memory enable rises at least one clock after done and after release.
// [RULE_16] Late release: inputs one clock after it, outputs two clocks after it.
// [RULE_17] External address source is sequential from zero, stepped by the strobe.
// [RULE_18] Serial store holds address at zero and floats data while enable is high.
// [RULE_19] Serial store drives on enable fall; first bit caught two clocks later.
// [RULE_20] Mode 2 packs eight bits a byte; strobe holds during row writes.
// [RULE_21] Mode 2 reports done and fault exactly as mode 1.
// [RULE_22] Mode 3 is mode 2 with eight bits per access.
// [RULE_23] Load starts on boot initiate fall, power up, or reset release.
// [RULE_24] Data bus captured on every second configuration clock edge; the code pauses capture while the row buffer is full.
// [RULE_25] Each load starts by clearing configuration memory before enable falls.
// [RULE_26] Fault reports check mismatch or wrong identifier; open-drain output.
// [RULE_27] A mode input selects modes 1, 2 and 3.
`timescale 1ns/100ps
module rom_boot_config_loader (
  input  wire logic                                clk_i,
  input  wire logic                                reset_i,
  input  wire logic                                clk_en_i,
  input  wire logic [1:0]                          mode_i,
  input  wire logic                                boot_initiate_n_i,
  input  wire logic                                power_up_release_i,
  input  wire logic [cfg_loader_pkg::DATA_W-1:0]    data_i,
  input  wire logic                                data_advance_strobe_i,
  output logic                                     data_advance_strobe_o,
  output logic                                     data_advance_strobe_oe_o,
  output logic      [cfg_loader_pkg::ADDR_W-1:0]    cfg_rom_pointer_o,
  output logic                                     cfg_rom_pointer_oe_o,
  output logic                                     memory_enable_n_o,
  output logic                                     load_done_o,
  output logic                                     load_fault_o,
  output logic                                     load_fault_oe_o,
  output logic                                     write_start_mark_o,
  output logic                                     write_finish_mark_o,
  output logic                                     row_write_valid_o,
  input  wire logic                                row_write_ready_i,
  output logic      [cfg_loader_pkg::DATA_W-1:0]    row_write_data_o,
  output logic                                     config_clear_o,
  output logic                                     user_inputs_en_o,
  output logic                                     user_outputs_en_o
);

  cfg_loader_pkg::load_state_t state_reg, state_next;

  logic [cfg_loader_pkg::ADDR_W-1:0]         addr_reg;
  logic [cfg_loader_pkg::ROW_IDX_W-1:0]      byte_idx_reg;
  logic [cfg_loader_pkg::ROW_NUM_W-1:0]      row_reg;
  logic [cfg_loader_pkg::BIT_IDX_W-1:0]      bit_idx_reg;
  logic [cfg_loader_pkg::DATA_W-1:0]         shift_reg;
  logic [cfg_loader_pkg::DATA_W-1:0]         check_reg;
  logic [cfg_loader_pkg::DATA_W-1:0]         row_data_reg [cfg_loader_pkg::ROW_BYTES];
  logic [cfg_loader_pkg::CLEAR_CYCLES_W-1:0] clear_cnt_reg;
  logic [1:0]                                wait_reg;
  logic                                      phase_reg;
  logic                                      boot_prev_reg;
  logic                                      strobe_prev_reg;
  logic                                      release_reg;
  logic                                      fault_pend_reg;
  logic                                      fault_cnt_reg;

  wire       boot_fall;
  wire       capture;
  wire       serial_mode;
  wire [7:0] captured_byte;
  wire       byte_ready;
  wire       row_complete;
  wire       check_ok;
  wire       id_ok;
  wire       buf_ready;
  wire       strobe_rise_in;
  wire       counting_after;

  // Accept only one defined mode code on each decode point
  function automatic logic mode_is(input logic [1:0] m, input logic [1:0] code);
    mode_is = (m == code);
  endfunction

  assign serial_mode    = mode_is(mode_i, cfg_loader_pkg::MODE_SERIAL);                // [RULE_27]
  assign boot_fall      = boot_prev_reg & ~boot_initiate_n_i;                         // [RULE_23]
  // Capture on alternate clocks while fetching; a full buffer stalls the fetch
  assign capture        = (state_reg == cfg_loader_pkg::ST_FETCH) & phase_reg & buf_ready; // [RULE_24]
  assign captured_byte  = serial_mode ? {shift_reg[6:0], data_i[0]} : data_i;          // [RULE_20] [RULE_22]
  assign byte_ready     = capture & (~serial_mode | (bit_idx_reg == cfg_loader_pkg::BIT_LAST));
  assign row_complete   = byte_ready & (byte_idx_reg == cfg_loader_pkg::CHECK_IDX);
  assign check_ok       = (captured_byte == check_reg);                               // [RULE_10]
  assign id_ok          = (row_reg != cfg_loader_pkg::ROW_ZERO) | (row_data_reg[0] == cfg_loader_pkg::ID_BYTE);
  assign strobe_rise_in = data_advance_strobe_i & ~strobe_prev_reg;
  assign counting_after = mode_is(mode_i, cfg_loader_pkg::MODE_INT_ADDR) & ~release_reg;

  // Row bytes go through the two-entry buffer to the configuration array port
  cfg_skid_buffer u_row_buffer (
    .clk_i       (clk_i),
    .reset_i     (reset_i),
    .enable_i    (clk_en_i),
    .in_valid_i  (byte_ready & (byte_idx_reg != cfg_loader_pkg::CHECK_IDX)),
    .in_ready_o  (buf_ready),
    .in_data_i   (captured_byte),
    .out_valid_o (row_write_valid_o),
    .out_ready_i (row_write_ready_i),
    .out_data_o  (row_write_data_o)
  );

  // Sequencer next state
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      cfg_loader_pkg::ST_CLEAR: begin
        if (clear_cnt_reg == cfg_loader_pkg::CLEAR_CYCLES) begin
          state_next = cfg_loader_pkg::ST_PRE;                                       // [RULE_25]
        end
      end
      cfg_loader_pkg::ST_PRE: begin
        state_next = cfg_loader_pkg::ST_FETCH;                                       // [RULE_03]
      end
      cfg_loader_pkg::ST_FETCH: begin
        if (row_complete & ~(check_ok & id_ok)) begin
          state_next = cfg_loader_pkg::ST_FAULT;                                     // [RULE_26]
        end else if (row_complete) begin
          state_next = cfg_loader_pkg::ST_WRITE;                                     // [RULE_06]
        end
      end
      cfg_loader_pkg::ST_WRITE: begin
        if ((wait_reg == cfg_loader_pkg::WRITE_CYCLES) & ~row_write_valid_o) begin
          state_next = (row_reg == cfg_loader_pkg::ROW_LAST) ? cfg_loader_pkg::ST_DONE
                                                             : cfg_loader_pkg::ST_FETCH; // [RULE_07]
        end
      end
      cfg_loader_pkg::ST_DONE: begin
        if (power_up_release_i) begin
          state_next = cfg_loader_pkg::ST_INPUTS;                                    // [RULE_15] [RULE_16]
        end
      end
      cfg_loader_pkg::ST_INPUTS: begin
        state_next = cfg_loader_pkg::ST_USER;                                        // [RULE_09]
      end
      cfg_loader_pkg::ST_USER: begin
        state_next = cfg_loader_pkg::ST_USER;
      end
      cfg_loader_pkg::ST_FAULT: begin
        state_next = cfg_loader_pkg::ST_FAULT;                                       // [RULE_11]
      end
      default: begin
        state_next = cfg_loader_pkg::ST_CLEAR;
      end
    endcase
  end

  // State register; a boot initiate fall restarts from the clear phase
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_reg     <= cfg_loader_pkg::ST_CLEAR;                                     // [RULE_23]
      boot_prev_reg <= 1'b1;
    end else if (clk_en_i) begin
      boot_prev_reg <= boot_initiate_n_i;
      state_reg     <= boot_fall ? cfg_loader_pkg::ST_CLEAR : state_next;           // [RULE_13] [RULE_14]
    end
  end

  // Clear timer, capture phase and row write wait
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      clear_cnt_reg <= cfg_loader_pkg::CLEAR_ZERO;
      phase_reg     <= 1'b0;
      wait_reg      <= cfg_loader_pkg::WAIT_ZERO;
    end else if (clk_en_i) begin
      clear_cnt_reg <= (state_reg == cfg_loader_pkg::ST_CLEAR) & ~boot_fall ?
                       clear_cnt_reg + cfg_loader_pkg::CLEAR_ONE : cfg_loader_pkg::CLEAR_ZERO;
      // Phase rises one clock after enable falls so first capture is two clocks later
      phase_reg     <= (state_reg == cfg_loader_pkg::ST_FETCH) & buf_ready ? ~phase_reg : 1'b0; // [RULE_04]
      wait_reg      <= (state_reg == cfg_loader_pkg::ST_WRITE) & (wait_reg != cfg_loader_pkg::WRITE_CYCLES) ?
                       wait_reg + cfg_loader_pkg::WAIT_ONE : cfg_loader_pkg::WAIT_ZERO;
    end
  end

  // Byte, bit and row counters plus running check byte
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      byte_idx_reg <= cfg_loader_pkg::IDX_ZERO;
      bit_idx_reg  <= cfg_loader_pkg::BIT_ZERO;
      row_reg      <= cfg_loader_pkg::ROW_ZERO;
      shift_reg    <= cfg_loader_pkg::CHECK_SEED;
      check_reg    <= cfg_loader_pkg::CHECK_SEED;
    end else if (clk_en_i) begin
      if (state_reg == cfg_loader_pkg::ST_CLEAR) begin
        byte_idx_reg <= cfg_loader_pkg::IDX_ZERO;
        bit_idx_reg  <= cfg_loader_pkg::BIT_ZERO;
        row_reg      <= cfg_loader_pkg::ROW_ZERO;
        check_reg    <= cfg_loader_pkg::CHECK_SEED;
      end else if (capture) begin
        shift_reg   <= captured_byte;
        bit_idx_reg <= serial_mode ? bit_idx_reg + cfg_loader_pkg::BIT_ONE : cfg_loader_pkg::BIT_ZERO; // [RULE_20]
        if (byte_ready) begin
          byte_idx_reg <= row_complete ? cfg_loader_pkg::IDX_ZERO : byte_idx_reg + cfg_loader_pkg::IDX_ONE;
          check_reg    <= row_complete ? cfg_loader_pkg::CHECK_SEED : check_reg ^ captured_byte;
        end
      end else if ((state_reg == cfg_loader_pkg::ST_WRITE) & (state_next != cfg_loader_pkg::ST_WRITE)) begin
        row_reg <= row_reg + cfg_loader_pkg::ROW_ONE;
      end
    end
  end

  // Row data register, one entry per byte position
  generate
    for (genvar i = 0; i < cfg_loader_pkg::ROW_BYTES; i++) begin : g_row
      always_ff @(posedge clk_i) begin
        if (clk_en_i & byte_ready & (byte_idx_reg == i[cfg_loader_pkg::ROW_IDX_W-1:0])) begin
          row_data_reg[i] <= captured_byte;
        end
      end
    end
  endgenerate

  // Address counter steps on each capture, and after done in mode 1 on each rising strobe until release
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      addr_reg        <= cfg_loader_pkg::ADDR_ZERO;
      strobe_prev_reg <= 1'b1;
      release_reg     <= 1'b0;
    end else if (clk_en_i) begin
      strobe_prev_reg <= data_advance_strobe_i;
      release_reg     <= (state_reg == cfg_loader_pkg::ST_CLEAR) ? 1'b0 : release_reg | power_up_release_i;
      if (state_reg == cfg_loader_pkg::ST_CLEAR) begin
        addr_reg <= cfg_loader_pkg::ADDR_ZERO;
      end else if (capture) begin
        addr_reg <= addr_reg + cfg_loader_pkg::ADDR_ONE;                             // [RULE_05]
      end else if ((state_reg == cfg_loader_pkg::ST_DONE) & counting_after & strobe_rise_in) begin
        addr_reg <= addr_reg + cfg_loader_pkg::ADDR_ONE;                             // [RULE_12]
      end
    end
  end

  // Fault delay: asserted two clocks after the bad check byte
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      fault_pend_reg <= 1'b0;
      fault_cnt_reg  <= 1'b0;
    end else if (clk_en_i) begin
      fault_pend_reg <= (state_next == cfg_loader_pkg::ST_FAULT) & ~boot_fall;
      fault_cnt_reg  <= fault_pend_reg & ~boot_fall;                                 // [RULE_10] [RULE_21]
    end
  end

  // Registered pin drives
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      memory_enable_n_o        <= 1'b1;
      data_advance_strobe_o    <= 1'b0;
      data_advance_strobe_oe_o <= 1'b0;
      cfg_rom_pointer_o        <= cfg_loader_pkg::ADDR_ZERO;
      cfg_rom_pointer_oe_o     <= 1'b0;
      load_done_o              <= 1'b0;
      load_fault_o             <= 1'b0;
      load_fault_oe_o          <= 1'b0;
      write_start_mark_o       <= 1'b0;
      write_finish_mark_o      <= 1'b0;
      config_clear_o           <= 1'b0;
      user_inputs_en_o         <= 1'b0;
      user_outputs_en_o        <= 1'b0;
    end else if (clk_en_i) begin
      memory_enable_n_o        <= ~((state_next == cfg_loader_pkg::ST_FETCH) | (state_next == cfg_loader_pkg::ST_WRITE)
                                    | (state_next == cfg_loader_pkg::ST_DONE)) | boot_fall; // [RULE_13] [RULE_15]
      data_advance_strobe_oe_o <= ~boot_fall & ((state_next == cfg_loader_pkg::ST_PRE)
                                  | (state_next == cfg_loader_pkg::ST_FETCH)
                                  | (state_next == cfg_loader_pkg::ST_WRITE));       // [RULE_03] [RULE_08] [RULE_12]
      data_advance_strobe_o    <= (state_next == cfg_loader_pkg::ST_WRITE) | capture; // [RULE_06] [RULE_19]
      cfg_rom_pointer_oe_o     <= ~boot_fall & mode_is(mode_i, cfg_loader_pkg::MODE_INT_ADDR)
                                  & ((state_next == cfg_loader_pkg::ST_FETCH) | (state_next == cfg_loader_pkg::ST_WRITE)
                                  | (state_next == cfg_loader_pkg::ST_DONE));       // [RULE_01] [RULE_02]
      cfg_rom_pointer_o        <= capture ? addr_reg + cfg_loader_pkg::ADDR_ONE : addr_reg; // [RULE_04]
      load_done_o              <= ~boot_fall & ((state_next == cfg_loader_pkg::ST_DONE)
                                  | (state_next == cfg_loader_pkg::ST_INPUTS) | (state_next == cfg_loader_pkg::ST_USER)); // [RULE_08] [RULE_14]
      load_fault_o             <= 1'b0;
      load_fault_oe_o          <= fault_cnt_reg & ~boot_fall;                        // [RULE_26]
      write_start_mark_o       <= (state_reg != cfg_loader_pkg::ST_WRITE) & (state_next == cfg_loader_pkg::ST_WRITE); // [RULE_07]
      write_finish_mark_o      <= (state_reg == cfg_loader_pkg::ST_WRITE) & (state_next != cfg_loader_pkg::ST_WRITE);
      config_clear_o           <= (state_next == cfg_loader_pkg::ST_CLEAR) | boot_fall; // [RULE_25]
      user_inputs_en_o         <= ~boot_fall & ((state_next == cfg_loader_pkg::ST_INPUTS)
                                  | (state_next == cfg_loader_pkg::ST_USER));       // [RULE_08] [RULE_16]
      user_outputs_en_o        <= ~boot_fall & (state_next == cfg_loader_pkg::ST_USER); // [RULE_09] [RULE_14]
    end
  end

endmodule

// [rom_boot_config_loader_assertions.sv]
// Checker of the loader's sequencing at its ports
`timescale 1ns/100ps
module rom_boot_config_loader_assertions (
  input wire logic        clk_i,
  input wire logic        reset_i,
  input wire logic [1:0]  mode_i,
  input wire logic        boot_initiate_n_i,
  input wire logic        power_up_release_i,
  input wire logic        data_advance_strobe_o,
  input wire logic        data_advance_strobe_oe_o,
  input wire logic [17:0] cfg_rom_pointer_o,
  input wire logic        cfg_rom_pointer_oe_o,
  input wire logic        memory_enable_n_o,
  input wire logic        load_done_o,
  input wire logic        load_fault_oe_o,
  input wire logic        write_start_mark_o,
  input wire logic        write_finish_mark_o,
  input wire logic        config_clear_o,
  input wire logic        user_inputs_en_o,
  input wire logic        user_outputs_en_o
);
  // One clock domain, so clocking and disable are stated once
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  AST_STROBE_LEAD: assert property (
    $fell(memory_enable_n_o) |-> $past(data_advance_strobe_oe_o) && !$past(data_advance_strobe_oe_o, 2))
    else $error("strobe drive did not lead enable by one clock");
  AST_FIRST_ADDR: assert property (
    $fell(memory_enable_n_o) && mode_i == 2'h1 |-> cfg_rom_pointer_oe_o && cfg_rom_pointer_o == 18'h00000)
    else $error("first address missing at enable fall");
  AST_CLEAR_FIRST: assert property (
    $fell(memory_enable_n_o) |-> $past(config_clear_o, 2)) else $error("enable fell without clear phase");
  AST_POINTER_STEP: assert property (
    $rose(data_advance_strobe_o) && cfg_rom_pointer_oe_o |-> cfg_rom_pointer_o == $past(cfg_rom_pointer_o) + 18'h00001)
    else $error("address did not step with strobe");
  AST_WRITE_HOLD: assert property (
    write_start_mark_o |=> (data_advance_strobe_o && $stable(cfg_rom_pointer_o)) until write_finish_mark_o)
    else $error("strobe or address moved during row write");
  AST_WRITE_BRACKET: assert property (
    write_start_mark_o |-> ##[1:200] write_finish_mark_o) else $error("row write never finished");
  AST_USER_SEQ: assert property (
    $rose(user_inputs_en_o) |-> $past(load_done_o) && $past(power_up_release_i) && memory_enable_n_o
      && !data_advance_strobe_oe_o ##1 user_outputs_en_o) else $error("user enable order broken");
  AST_FAULT_STOPS: assert property (
    $rose(load_fault_oe_o) |=> (load_fault_oe_o && !load_done_o && !write_start_mark_o)[*8])
    else $error("loading went on after fault");
  AST_BOOT_DROP: assert property (
    $fell(boot_initiate_n_i) |-> ##[0:3] (memory_enable_n_o && !load_done_o && !user_outputs_en_o))
    else $error("boot initiate did not stop the device");
endmodule

// [rom_boot_config_loader_tb.sv]
// Self-checking bench for the configuration loader
`timescale 1ns/100ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin fails++; \
  $display("ERROR t=%0t got=%0h exp=%0h", $time, a, b); end end
`define WAITF(c) begin for (w = 0; w < 4000 && !(c); w++) @(negedge clk_i); \
  if (w == 4000) begin fails++; tally_and_finish(); end end
module rom_boot_config_loader_tb;
  logic clk_i = 0, reset_i = 1, clk_en_i = 1, boot_initiate_n_i = 1, power_up_release_i = 1;
  logic row_write_ready_i = 1, stall = 0, bad = 0, pull_strobe = 1, got = 0;
  logic [1:0] mode_i = 2'h1;
  logic [7:0] data_i, row_write_data_o, first, cyc = 8'h00;
  logic [17:0] cfg_rom_pointer_o, p;
  logic data_advance_strobe_i, data_advance_strobe_o, data_advance_strobe_oe_o, cfg_rom_pointer_oe_o;
  logic memory_enable_n_o, load_done_o, load_fault_o, load_fault_oe_o, write_start_mark_o;
  logic write_finish_mark_o, row_write_valid_o, config_clear_o, user_inputs_en_o, user_outputs_en_o;
  int fails = 0, tests_run = 0, w;
  // Strobe pin has a pull-up once the loader stops driving it
  assign data_advance_strobe_i = data_advance_strobe_oe_o ? data_advance_strobe_o : pull_strobe;
  rom_boot_config_loader dut (.*);
  cfg_store_model mem (.clk_i(clk_i), .mode_i(mode_i), .strobe_i(data_advance_strobe_i),
    .memory_enable_n_i(memory_enable_n_o), .pointer_i(cfg_rom_pointer_o), .bad_i(bad), .data_o(data_i));
  initial begin
    forever #2.5 clk_i = ~clk_i;
  end
  // Receiver stalls 16 of every 32 cycles when asked, to fill the buffer
  always @(negedge clk_i) begin
    cyc <= cyc + 8'h01;
    row_write_ready_i <= !(stall && cyc[4]);
  end
  // First byte of each load's row stream
  always @(posedge clk_i) begin
    if (memory_enable_n_o) got <= 1'b0;
    else if (row_write_valid_o && row_write_ready_i && !got) begin
      first <= row_write_data_o;
      got <= 1'b1;
    end
  end
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic restart(logic [1:0] m, logic st);
    mode_i = m;
    stall = st;
    boot_initiate_n_i = 0;
    repeat (3) @(negedge clk_i);
    `CHK({memory_enable_n_o, load_done_o, user_outputs_en_o}, 3'b100)
    repeat (7) @(negedge clk_i);
    boot_initiate_n_i = 1;
  endtask
  task automatic t_load(logic [1:0] m, logic st);
    restart(m, st);
    `WAITF(load_done_o)
    `CHK({user_inputs_en_o, memory_enable_n_o, load_fault_oe_o}, 3'b000)
    `CHK(first, cfg_loader_pkg::ID_BYTE)
    @(negedge clk_i);
    `CHK({user_inputs_en_o, memory_enable_n_o, data_advance_strobe_oe_o}, 3'b110)
    @(negedge clk_i);
    `CHK(user_outputs_en_o, 1'b1)
    $display("load in mode %0d finished", m);
  endtask
  task automatic t_late();
    power_up_release_i = 0;
    restart(cfg_loader_pkg::MODE_INT_ADDR, 0);
    `WAITF(load_done_o)
    repeat (4) @(negedge clk_i);
    `CHK({user_inputs_en_o, memory_enable_n_o}, 2'b00)
    p = cfg_rom_pointer_o;
    pull_strobe = 0;
    @(negedge clk_i);
    pull_strobe = 1;
    repeat (2) @(negedge clk_i);
    `CHK(cfg_rom_pointer_o, p + 18'h00001)
    power_up_release_i = 1;
    @(negedge clk_i);
    `CHK({user_inputs_en_o, user_outputs_en_o}, 2'b10)
    @(negedge clk_i);
    `CHK(user_outputs_en_o, 1'b1)
    $display("late release finished");
  endtask
  task automatic t_fault();
    bad = 1;
    restart(cfg_loader_pkg::MODE_INT_ADDR, 0);
    `WAITF(cfg_rom_pointer_o == 18'h00010)
    @(negedge clk_i);
    `CHK(load_fault_oe_o, 1'b0)
    @(negedge clk_i);
    `CHK(load_fault_oe_o, 1'b1)
    repeat (20) @(negedge clk_i);
    `CHK({load_fault_oe_o, load_done_o, load_fault_o}, 3'b100)
    bad = 0;
    $display("check byte fault finished");
  endtask
  initial begin
    repeat (5) @(negedge clk_i);
    reset_i = 0;
    `WAITF(load_done_o)
    t_load(cfg_loader_pkg::MODE_INT_ADDR, 0);
    t_load(cfg_loader_pkg::MODE_SERIAL, 0);
    t_load(cfg_loader_pkg::MODE_EXT_BYTE, 1);
    t_late();
    t_fault();
    t_load(cfg_loader_pkg::MODE_INT_ADDR, 1);
    tally_and_finish();
  end
endmodule
bind rom_boot_config_loader rom_boot_config_loader_assertions chk (.*);
